// ===== rtl/udc_cfg_defs.svh
// constants for the device configuration and interrupt enable bank
`ifndef UDC_CFG_DEFS_SVH
`define UDC_CFG_DEFS_SVH

// command codes
`define UDC_CMD_CFG_WR 8'hBA
`define UDC_CMD_CFG_RD 8'hBB
`define UDC_CMD_IEN_WR 8'hC2
`define UDC_CMD_IEN_RD 8'hC3

// configuration field positions
`define UDC_CFG_ACK_ONLY 7
`define UDC_CFG_DRQ_POL 6
`define UDC_CFG_DACK_POL 5
`define UDC_CFG_EOT_POL 4
`define UDC_CFG_CS_WAKE 3
`define UDC_CFG_PWR_OFF 2
`define UDC_CFG_IRQ_PULSE 1
`define UDC_CFG_IRQ_POL 0

// reset values and configuration write mask
`define UDC_CFG_RESET 16'h2340
`define UDC_CFG_MASK 16'h7FFF
`define UDC_IEN_RESET 32'h0000_0000

// interrupt pulse width
`define UDC_CLK_PERIOD_NS 20
`define UDC_IRQ_PULSE_NS 166
`define UDC_IRQ_PULSE_CYC (`UDC_IRQ_PULSE_NS / `UDC_CLK_PERIOD_NS)

`endif

// ===== rtl/udc_cfg_pkg.sv
// types for the device configuration and interrupt enable bank
package udc_cfg_pkg;
  typedef enum logic [1:0]
  {
    UDC_IDLE = 2'b00,
    UDC_DATA0 = 2'b01,
    UDC_DATA1 = 2'b10
  } udc_phase_t;

  typedef logic [15:0] udc_word_t;
endpackage

// ===== rtl/udc_cfg.sv
// device configuration word, interrupt enables and event capture
`timescale 1ns/100ps
`default_nettype none
`include "udc_cfg_defs.svh"

// Function
// - bit 7 picks ack-only or classic DMA
// - bit 6 sets DMA request polarity
// - bit 5 sets DMA acknowledge polarity
// - bit 4 sets end-of-transfer polarity
// - bit 3 enables chip-select wake with bus power
// - bit 2 drives suspend output as power switch; here only stored and read back
// - bit 1 picks level or pulse irq; 166 ns asked, 8 cycles of 20 ns give 160 ns
// - bit 0 sets interrupt output polarity
// - bus reset keeps configuration bits
// - enables for endpoints and six bus events
// - disabled events neither recorded nor signalled
// - only events starting after enable count
// - enables gate status capture, not the output
// - bus reset keeps interrupt enables
// - enables written C2, read C3, two words
// - configuration written BA, read BB, one word
// - global enable needed before irq output
module udc_cfg #(
  parameter int NUM_EVENTS = 32,
  parameter int PULSE_CYC = `UDC_IRQ_PULSE_CYC
)(
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  // command port
  input wire logic cmd_strobe,
  input wire logic [7:0] cmd_code,
  input wire logic data_wr_strobe,
  input wire logic data_rd_strobe,
  input wire udc_cfg_pkg::udc_word_t data_wr,
  output udc_cfg_pkg::udc_word_t data_rd,
  // mode register bit and status clear
  input wire logic global_irq_enable,
  input wire logic [NUM_EVENTS-1:0] status_clear,
  // event sources, level high while an event is in progress
  input wire logic [NUM_EVENTS-1:0] event_in,
  // suspend and power
  input wire logic suspended,
  input wire logic vbus_present,
  input wire logic chip_select_n,
  // dma pins and internal dma side
  input wire logic dma_request,
  input wire logic device_dma_ack_in,
  input wire logic transfer_end_in,
  output logic device_dma_request_out,
  output logic dma_ack_active,
  output logic transfer_end_active,
  output logic ack_only_dma_select,
  // outputs to pins
  output logic device_irq_out,
  output logic suspend_out,
  output logic remote_wakeup,
  output logic [NUM_EVENTS-1:0] device_interrupt_status
);
  import udc_cfg_pkg::*;

  // limitations: no usb bus reset reaches this bank, so configuration
  // and enables change only by writes or nrst; the power-off bit is
  // stored and read back, while suspend_out already tracks suspend
  // a clock slower than the pulse width still gives a one-cycle pulse
  localparam int PW = (PULSE_CYC < 1) ? 1 : PULSE_CYC;

  udc_word_t device_hardware_configuration;
  logic [31:0] device_interrupt_enables;
  udc_phase_t phase;
  udc_phase_t next_phase;
  logic [7:0] cur_cmd;
  logic [NUM_EVENTS-1:0] event_prev;
  logic [NUM_EVENTS-1:0] next_status;
  logic irq_level;
  logic irq_level_d;
  logic [7:0] pulse_cnt;
  logic irq_assert;
  // decoded command-time and data-phase strobes
  logic cfg_wr_hit;
  logic ien_lo_hit;
  logic ien_hi_hit;
  logic rd_cfg_first;
  logic rd_ien_first;
  logic rd_ien_second;
  // decoded configuration fields
  logic fld_ack_only;
  logic fld_drq_pol;
  logic fld_dack_pol;
  logic fld_eot_pol;
  logic fld_cs_wake;
  logic fld_irq_pulse;
  logic fld_irq_pol;
  logic [NUM_EVENTS-1:0] event_rise;

  // apply a polarity bit: 1 means active high
  function automatic logic pol(input logic active, input logic high);
    pol = high ? active : ~active;
  endfunction

  // a command code accepted by this bank
  function automatic logic known_cmd(input logic [7:0] c);
    known_cmd = (c == `UDC_CMD_CFG_WR) || (c == `UDC_CMD_CFG_RD) ||
                (c == `UDC_CMD_IEN_WR) || (c == `UDC_CMD_IEN_RD);
  endfunction

  // write and second-read strobes qualified by phase and latched command,
  // first reads by the new command code; a new command in the same cycle wins, so a stray strobe cannot hit a stale command
  always_comb
  begin
    cfg_wr_hit = data_wr_strobe && !cmd_strobe && phase == UDC_DATA0 &&
                 cur_cmd == `UDC_CMD_CFG_WR;
    ien_lo_hit = data_wr_strobe && !cmd_strobe && phase == UDC_DATA0 &&
                 cur_cmd == `UDC_CMD_IEN_WR;
    ien_hi_hit = data_wr_strobe && !cmd_strobe && phase == UDC_DATA1 &&
                 cur_cmd == `UDC_CMD_IEN_WR;
    rd_cfg_first = cmd_strobe && cmd_code == `UDC_CMD_CFG_RD;
    rd_ien_first = cmd_strobe && cmd_code == `UDC_CMD_IEN_RD;
    rd_ien_second = data_rd_strobe && !cmd_strobe &&
                    phase == UDC_DATA0 && cur_cmd == `UDC_CMD_IEN_RD;
  end

  // named views of the lower configuration byte
  always_comb
  begin
    fld_ack_only = device_hardware_configuration[`UDC_CFG_ACK_ONLY];
    fld_drq_pol = device_hardware_configuration[`UDC_CFG_DRQ_POL];
    fld_dack_pol = device_hardware_configuration[`UDC_CFG_DACK_POL];
    fld_eot_pol = device_hardware_configuration[`UDC_CFG_EOT_POL];
    fld_cs_wake = device_hardware_configuration[`UDC_CFG_CS_WAKE];
    fld_irq_pulse = device_hardware_configuration[`UDC_CFG_IRQ_PULSE];
    fld_irq_pol = device_hardware_configuration[`UDC_CFG_IRQ_POL];
  end

  // data phase sequencing: one word for config, two for enables
  always_comb
  begin
    next_phase = phase;
    if (cmd_strobe)
    begin
      next_phase = known_cmd(cmd_code) ? UDC_DATA0 : UDC_IDLE;
    end
    else if (data_wr_strobe || data_rd_strobe)
    begin
      case (phase)
        UDC_DATA0:
          next_phase = (cur_cmd == `UDC_CMD_IEN_WR ||
                        cur_cmd == `UDC_CMD_IEN_RD) ? UDC_DATA1 : UDC_IDLE;
        UDC_DATA1: next_phase = UDC_IDLE;
        default: next_phase = UDC_IDLE;
      endcase
    end
  end

  // command latch and phase register
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      phase <= UDC_IDLE;
      cur_cmd <= 8'h00;
    end
    else if (clk_en)
    begin
      phase <= next_phase;
      if (cmd_strobe)
      begin
        cur_cmd <= cmd_code;
      end
    end
  end

  // configuration register; a usb bus reset has no path here
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      device_hardware_configuration <= `UDC_CFG_RESET;
    end
    else if (clk_en && cfg_wr_hit)
    begin
      device_hardware_configuration <= data_wr & `UDC_CFG_MASK;
    end
  end

  // enable register, low word first; untouched by usb bus reset
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      device_interrupt_enables <= `UDC_IEN_RESET;
    end
    else if (clk_en)
    begin
      // a short sequence keeps the half already written
      if (ien_lo_hit)
      begin
        device_interrupt_enables[15:0] <= data_wr;
      end
      else if (ien_hi_hit)
      begin
        device_interrupt_enables[31:16] <= data_wr;
      end
    end
  end

  // read data: pure mux into a flop, no state changes on read; the
  // first word is loaded by the command itself so that it already
  // stands when the host takes it, before its first read strobe
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      data_rd <= 16'h0000;
    end
    else if (clk_en)
    begin
      if (rd_cfg_first)
      begin
        data_rd <= device_hardware_configuration;
      end
      else if (rd_ien_first)
      begin
        data_rd <= device_interrupt_enables[15:0];
      end
      else if (rd_ien_second)
      begin
        data_rd <= device_interrupt_enables[31:16];
      end
    end
  end

  // capture only rising edges of enabled events
  always_comb
  begin
    // an event already high when its enable is set has no edge left
    event_rise = event_in & ~event_prev;
    next_status = device_interrupt_status & ~status_clear;
    // set wins over clear; an edge seen only while enabled
    next_status = next_status | (event_rise &
                  device_interrupt_enables[NUM_EVENTS-1:0]);
  end

  // event history and status bits
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      event_prev <= '0;
      device_interrupt_status <= '0;
    end
    else if (clk_en)
    begin
      event_prev <= event_in;
      device_interrupt_status <= next_status;
    end
  end

  // interrupt level needs the global enable
  always_comb
  begin
    irq_level = global_irq_enable && (|device_interrupt_status);
  end

  // pulse timer: one pulse per rise of the level request
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      irq_level_d <= 1'b0;
      pulse_cnt <= 8'h00;
    end
    else if (clk_en)
    begin
      irq_level_d <= irq_level;
      if (irq_level && !irq_level_d)
      begin
        pulse_cnt <= 8'(PW);
      end
      else if (pulse_cnt != 8'h00)
      begin
        pulse_cnt <= pulse_cnt - 8'h01;
      end
    end
  end

  // active-state of the interrupt pin before polarity
  always_comb
  begin
    irq_assert = fld_irq_pulse ? (pulse_cnt != 8'h00) : irq_level;
  end

  // interrupt pin, registered so the pulse edges are clean
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      device_irq_out <= 1'b0;
    end
    else if (clk_en)
    begin
      device_irq_out <= pol(irq_assert, fld_irq_pol);
    end
  end

  // suspend and wake pins; the power-off bit needs no gate since the
  // plain suspend flag is already high for the whole suspend
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      suspend_out <= 1'b0;
      remote_wakeup <= 1'b0;
    end
    else if (clk_en)
    begin
      suspend_out <= suspended;
      // wake through chip select only with bus power present
      remote_wakeup <= suspended && vbus_present && !chip_select_n &&
                       fld_cs_wake;
    end
  end

  // dma pins: each sense converted once, right at the pin
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      device_dma_request_out <= 1'b0;
      dma_ack_active <= 1'b0;
      transfer_end_active <= 1'b0;
      ack_only_dma_select <= 1'b0;
    end
    else if (clk_en)
    begin
      device_dma_request_out <= pol(dma_request, fld_drq_pol);
      dma_ack_active <= pol(device_dma_ack_in, fld_dack_pol);
      transfer_end_active <= pol(transfer_end_in, fld_eot_pol);
      ack_only_dma_select <= fld_ack_only;
    end
  end

endmodule
`default_nettype wire

// ===== verif/udc_cfg_sva.sv
// checker for the configuration and interrupt enable bank
`timescale 1ns/100ps
`default_nettype none
module udc_cfg_sva #(
  parameter int NUM_EVENTS = 32,
  parameter int PULSE_CYC = 8
)(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // command port
  input wire logic cmd_strobe,
  input wire logic [7:0] cmd_code,
  input wire logic data_wr_strobe,
  input wire udc_cfg_pkg::udc_word_t data_wr,
  input wire udc_cfg_pkg::udc_word_t data_rd,
  // levels and pins
  input wire logic global_irq_enable,
  input wire logic suspended,
  input wire logic vbus_present,
  input wire logic chip_select_n,
  input wire logic dma_request,
  input wire logic device_dma_ack_in,
  input wire logic transfer_end_in,
  // outputs
  input wire logic device_dma_request_out,
  input wire logic dma_ack_active,
  input wire logic transfer_end_active,
  input wire logic ack_only_dma_select,
  input wire logic device_irq_out,
  input wire logic suspend_out,
  input wire logic remote_wakeup,
  input wire logic [NUM_EVENTS-1:0] device_interrupt_status
);
  import udc_cfg_pkg::*;
  logic [15:0] cfg_sh;
  logic cfg_wr;
  // shadow of the configuration word, fed from the command port
  always_ff @(posedge clk_sys)
  begin
    if (!nrst) cfg_sh <= 16'h2340;
    else if (cfg_wr && data_wr_strobe) cfg_sh <= data_wr & 16'h7FFF;
  end
  // write pending after a configuration write command
  always_ff @(posedge clk_sys)
  begin
    if (!nrst || cmd_strobe) cfg_wr <= nrst && cmd_code == 8'hBA;
    else if (data_wr_strobe) cfg_wr <= 1'b0;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // inputs before release are random, so skip the first edge
  sequence s_quiet;
    $past(nrst) && $stable(cfg_sh);
  endsequence
  sequence s_irq_rise;
    $rose(|device_interrupt_status) && global_irq_enable;
  endsequence
  AST_ACK_ONLY: assert property (s_quiet [*2] |->
    ack_only_dma_select == cfg_sh[7]) else $error("ack-only select");
  AST_DRQ_POL: assert property (s_quiet [*2] |->
    device_dma_request_out == ($past(dma_request) ^ ~cfg_sh[6]))
    else $error("request polarity");
  AST_DACK_POL: assert property (s_quiet [*2] |->
    dma_ack_active == ($past(device_dma_ack_in) ~^ cfg_sh[5]))
    else $error("ack polarity");
  AST_EOT_POL: assert property (s_quiet [*2] |->
    transfer_end_active == ($past(transfer_end_in) ~^ cfg_sh[4]))
    else $error("end polarity");
  AST_CS_WAKE: assert property (s_quiet [*2] |->
    remote_wakeup == ($past(suspended) && $past(vbus_present)
    && !$past(chip_select_n) && cfg_sh[3])) else $error("wake");
  AST_SUSPEND: assert property ($past(nrst) |->
    suspend_out == $past(suspended)) else $error("suspend output");
  AST_IRQ_LEVEL: assert property (s_irq_rise ##0 !cfg_sh[1] |=>
    device_irq_out == cfg_sh[0]) else $error("level irq");
  // the pin goes active one cycle after the pulse timer is loaded
  AST_IRQ_PULSE: assert property (s_irq_rise ##0 cfg_sh[1] |=>
    ##1 (device_irq_out == cfg_sh[0]) [*8] ##1 device_irq_out != cfg_sh[0])
    else $error("pulse irq");
  AST_CFG_READ: assert property (cmd_strobe && cmd_code == 8'hBB |=>
    data_rd == cfg_sh) else $error("config read");
endmodule
bind udc_cfg udc_cfg_sva #(.NUM_EVENTS(NUM_EVENTS), .PULSE_CYC(PULSE_CYC))
  u_sva (.*);
`default_nettype wire

// ===== verif/udc_dma_host.sv
// behavioural dma controller answering the device request pin
`timescale 1ns/100ps
`default_nettype none
module udc_dma_host (
  // clock, pace and configured senses
  input wire logic clk_sys,
  input wire logic slow,
  input wire logic [7:0] cfg,
  // device pins
  input wire logic device_dma_request_out,
  output logic device_dma_ack_in,
  output logic transfer_end_in
);
  logic [1:0] seen;
  // request read at its own sense; slow answers lag one more cycle
  always_ff @(posedge clk_sys)
  begin
    seen <= {seen[0], device_dma_request_out == cfg[6]};
  end
  assign device_dma_ack_in = (slow ? seen[1] : seen[0]) ~^ cfg[5];
  assign transfer_end_in = (seen[1] & ~seen[0]) ~^ cfg[4];
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// self-checking bench for the configuration and enable bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import udc_cfg_pkg::*;
  logic clk_sys = 0, nrst = 0, cmd_strobe = 0, data_wr_strobe = 0;
  logic data_rd_strobe = 0, global_irq_enable = 0, suspended = 0;
  logic vbus_present = 0, chip_select_n = 1, dma_request = 0;
  logic device_dma_ack_in, transfer_end_in, device_dma_request_out;
  logic dma_ack_active, transfer_end_active, ack_only_dma_select;
  logic device_irq_out, suspend_out, remote_wakeup;
  logic [7:0] cmd_code = 0, cfg_now = 8'h40;
  logic [31:0] event_in = 0, status_clear = 0, rnd = 83433;
  logic [31:0] device_interrupt_status;
  udc_word_t data_wr = 0, data_rd, w;
  logic [32:0] q[$];
  int miscompares = 0, tests_run = 0;
  event got;
  udc_cfg dut (.clk_en(1'b1), .*);
  udc_dma_host host (.slow(rnd[9]), .cfg(cfg_now), .*);
  always #10 clk_sys = ~clk_sys;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // random pin levels, moved on the falling edge
  always @(negedge clk_sys)
  begin
    rnd <= lfsr(rnd);
    {suspended, vbus_present, chip_select_n, dma_request} <= rnd[3:0];
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
      $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
    if (seen !== exp)
      miscompares++;
  endtask
  // oldest note against the output it names
  always @(got)
  begin
    logic [32:0] n;
    n = q.pop_front();
    chk(n[32] ? device_interrupt_status : {16'h0, data_rd}, n[31:0]);
  end
  task note(input logic s, input logic [31:0] e);
    q.push_back({s, e});
    ->got;
  endtask
  task cmd(input logic [7:0] c);
    @(negedge clk_sys);
    cmd_strobe = 1;
    cmd_code = c;
    @(negedge clk_sys);
    cmd_strobe = 0;
  endtask
  // command then data words, low word first
  task xfer(input logic [7:0] c, input logic [31:0] v, input int n,
    input logic rd);
    cmd(c);
    for (int i = 0; i < n; i++)
    begin
      if (rd) note(0, v[16*i +: 16]);
      data_wr = v[16*i +: 16];
      data_rd_strobe = rd;
      data_wr_strobe = !rd;
      @(negedge clk_sys);
    end
    data_rd_strobe = 0;
    data_wr_strobe = 0;
  endtask
  task results();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (3) @(negedge clk_sys);
    nrst = 1;
    xfer(8'hBB, 32'h2340, 1, 1);
    xfer(8'hC3, 32'h0, 2, 1);
    xfer(8'hC2, 32'hA5C3_000F, 2, 0);
    xfer(8'hC3, 32'hA5C3_000F, 2, 1);
    global_irq_enable = 1;
    event_in = 32'hFF;
    repeat (3) @(negedge clk_sys);
    note(1, 32'h0F);
    xfer(8'hC2, 32'hF0, 2, 0);
    repeat (2) @(negedge clk_sys);
    note(1, 32'h0F);
    event_in = 0;
    @(negedge clk_sys);
    event_in = 32'hFF;
    repeat (3) @(negedge clk_sys);
    note(1, 32'hFF);
    event_in = 0;
    status_clear = '1;
    @(negedge clk_sys);
    status_clear = 0;
    w = rnd[15:0] | 16'h0006;
    xfer(8'hBA, {16'h0000, w}, 1, 0);
    cfg_now = w[7:0];
    xfer(8'hBB, {16'h0000, w & 16'h7FFF}, 1, 1);
    xfer(8'hBB, {16'h0000, w & 16'h7FFF}, 1, 1);
    xfer(8'hC3, 32'h0000_00F0, 2, 1);
    event_in = 32'h10;
    repeat (12) @(negedge clk_sys);
    note(1, 32'h10);
    results();
  end
  // hang guard, far beyond the run length
  initial
  begin
    #20us;
    miscompares++;
    results();
  end
endmodule
`default_nettype wire
